// *** logic/serial_master_transfer_fsm.sv ***
/*
  master sequencer of a character serial transfer: enquiry, header, blocks.
  assumes received characters arrive already decoded as one-cycle events on
  mclk, and that the transmitter accepts one command per cycle.
*/
// Functional notes
// - idle request clears retries, sends quick or normal enquiry, waits.
// - ack to enquiry sends header, starts header timer, waits header ack.
// - header ack: read waits for text start; write fetches and sends block.
// - block ack: last block sends end and idles; else next block.
// - enquiry nak or timeout retries while count at most 32, else end.
// - header nak retries header while count at most 3, else end.
// - block nak resends block while count at most 3, else end.
// - start-of-text while waiting starts receive timer, waits for data.
// - good read block delivered and acked; last waits end, else next.
// - bad read block naks and rewaits while count at most 3, else end.
// - quick reply good idles; bad or timeout retries while count at most 3, silent give-up.
`timescale 1ns/1ps
module serial_master_transfer_fsm
  import master_xfer_pkg::*;
#(
  parameter int ENQ_REPLY = ENQ_REPLY_CYCLES,
  parameter int HDR_REPLY = HDR_REPLY_CYCLES,
  parameter int BLK_REPLY = BLK_REPLY_CYCLES,
  parameter int TEXT_START = TEXT_START_CYCLES,
  parameter int DATA_RECV = DATA_RECV_CYCLES,
  parameter int END_WAIT = END_WAIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rst,
  input xfer_req_s transferRequest,
  input rx_event_s rxEvent,
  input wire logic memDataValid,
  output tx_cmd_s txCmd_r,
  output logic memFetch_r,
  output logic memDeliver_r,
  output logic busy_r,
  output logic doneOk_r,
  output logic doneFail_r
);

  typedef enum logic [3:0] {
    S_IDLE, S_ENQ_ACK, S_HDR_ACK, S_DATA_ACK, S_TEXT_START, S_DATA, S_END, S_QUICK
  } state_e;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  state_e state_r, state_nxt;
  logic [5:0] enquiryRetryCount_r, enquiryRetryCount_nxt;
  logic [2:0] headerRetryCount_r, headerRetryCount_nxt;
  logic [2:0] blockRetryCount_r, blockRetryCount_nxt;
  logic [2:0] quickRetryCount_r, quickRetryCount_nxt;
  logic [BLOCKS_W-1:0] blocksLeft_r, blocksLeft_nxt;
  logic readDir_r, readDir_nxt;
  tx_cmd_s tx_nxt;
  logic fetch_nxt, deliver_nxt, ok_nxt, fail_nxt;
  logic timerStart, timerStop, timeout;
  logic [TIMER_W-1:0] timerLoad;

  // ---------------------------------------------------------------
  // event decode
  // ---------------------------------------------------------------
  wire rxAck = rxEvent.valid && rxEvent.kind == RX_ACK;
  wire rxNak = rxEvent.valid && rxEvent.kind == RX_NAK;
  wire rxStx = rxEvent.valid && rxEvent.kind == RX_STX;
  wire rxGood = rxEvent.valid && rxEvent.kind == RX_GOOD_DATA;
  wire rxBad = rxEvent.valid && rxEvent.kind == RX_BAD_DATA;
  // a character other than good data beats a timeout; good data is ignored outside the data waits
  wire rxStray = rxEvent.valid && !rxGood;
  wire tmo = timeout && !rxStray;
  wire lastBlock = blocksLeft_r <= {{(BLOCKS_W-1){1'b0}}, 1'b1};
  wire [BLOCKS_W-1:0] blocksDec = blocksLeft_r - {{(BLOCKS_W-1){1'b0}}, 1'b1};

  function automatic tx_cmd_s cmd(input tx_kind_e k);
    cmd.valid = 1'b1;
    cmd.kind = k;
  endfunction

  function automatic logic [TIMER_W-1:0] cyc(input int n);
    cyc = n[TIMER_W-1:0];
  endfunction

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    enquiryRetryCount_nxt = enquiryRetryCount_r;
    headerRetryCount_nxt = headerRetryCount_r;
    blockRetryCount_nxt = blockRetryCount_r;
    quickRetryCount_nxt = quickRetryCount_r;
    blocksLeft_nxt = blocksLeft_r;
    readDir_nxt = readDir_r;
    tx_nxt = '0;
    fetch_nxt = 1'b0;
    deliver_nxt = 1'b0;
    ok_nxt = 1'b0;
    fail_nxt = 1'b0;
    timerStart = 1'b0;
    timerStop = 1'b0;
    timerLoad = cyc(ENQ_REPLY);
    case (state_r)
      S_IDLE: begin
        if (transferRequest.valid) begin
          enquiryRetryCount_nxt = '0;
          headerRetryCount_nxt = '0;
          blockRetryCount_nxt = '0;
          quickRetryCount_nxt = '0;
          readDir_nxt = transferRequest.read;
          blocksLeft_nxt = transferRequest.blocks;
          timerStart = 1'b1;
          if (transferRequest.quick) begin
            tx_nxt = cmd(TX_QUICK_ENQ);
            state_nxt = S_QUICK;
          end else begin
            tx_nxt = cmd(TX_ENQ);
            state_nxt = S_ENQ_ACK;
          end
        end
      end
      S_ENQ_ACK: begin
        if (rxAck) begin
          tx_nxt = cmd(TX_HEADER);
          timerStart = 1'b1;
          timerLoad = cyc(HDR_REPLY);
          state_nxt = S_HDR_ACK;
        end else if ((rxNak || tmo) && enquiryRetryCount_r <= ENQUIRY_RETRY_LIMIT) begin
          enquiryRetryCount_nxt = enquiryRetryCount_r + 6'h01;
          tx_nxt = cmd(TX_ENQ);
          timerStart = 1'b1;
        end else if (rxStray || tmo) begin
          state_nxt = S_IDLE;
        end
      end
      S_HDR_ACK: begin
        if (rxAck && readDir_r) begin
          timerStart = 1'b1;
          timerLoad = cyc(TEXT_START);
          state_nxt = S_TEXT_START;
        end else if (rxAck) begin
          fetch_nxt = 1'b1;
          timerStop = 1'b1;
          state_nxt = S_DATA_ACK;
        end else if (rxNak && headerRetryCount_r <= HEADER_RETRY_LIMIT) begin
          headerRetryCount_nxt = headerRetryCount_r + 3'h1;
          tx_nxt = cmd(TX_HEADER);
          timerStart = 1'b1;
          timerLoad = cyc(HDR_REPLY);
        end else if (rxStray || tmo) begin
          state_nxt = S_IDLE;
        end
      end
      S_DATA_ACK: begin
        if (memDataValid && !rxStray) begin
          blockRetryCount_nxt = '0;
          tx_nxt = cmd(TX_DATA);
          timerStart = 1'b1;
          timerLoad = cyc(BLK_REPLY);
        end else if (rxAck && lastBlock) begin
          ok_nxt = 1'b1;
          state_nxt = S_IDLE;
        end else if (rxAck) begin
          blocksLeft_nxt = blocksDec;
          fetch_nxt = 1'b1;
          timerStop = 1'b1;
        end else if (rxNak && blockRetryCount_r <= BLOCK_RETRY_LIMIT) begin
          blockRetryCount_nxt = blockRetryCount_r + 3'h1;
          tx_nxt = cmd(TX_DATA);
          timerStart = 1'b1;
          timerLoad = cyc(BLK_REPLY);
        end else if (rxStray || tmo) begin
          state_nxt = S_IDLE;
        end
      end
      S_TEXT_START: begin
        if (rxStx) begin
          timerStart = 1'b1;
          timerLoad = cyc(DATA_RECV);
          state_nxt = S_DATA;
        end else if (rxStray || tmo) begin
          state_nxt = S_IDLE;
        end
      end
      S_DATA: begin
        if (rxGood) begin
          deliver_nxt = 1'b1;
          tx_nxt = cmd(TX_ACK);
          timerStart = 1'b1;
          blockRetryCount_nxt = '0;
          blocksLeft_nxt = blocksDec;
          timerLoad = lastBlock ? cyc(END_WAIT) : cyc(TEXT_START);
          state_nxt = lastBlock ? S_END : S_TEXT_START;
        end else if (rxBad && blockRetryCount_r <= BLOCK_RETRY_LIMIT) begin
          blockRetryCount_nxt = blockRetryCount_r + 3'h1;
          tx_nxt = cmd(TX_NAK);
          timerStart = 1'b1;
          timerLoad = cyc(TEXT_START);
          state_nxt = S_TEXT_START;
        end else if (rxBad || tmo) begin
          state_nxt = S_IDLE;
        end
      end
      S_END: begin
        if (rxStray || tmo) begin
          state_nxt = S_IDLE;
          ok_nxt = rxEvent.valid && rxEvent.kind == RX_EOT;
        end
      end
      S_QUICK: begin
        if (rxGood) begin
          ok_nxt = 1'b1;
          state_nxt = S_IDLE;
        end else if ((rxBad || tmo) && quickRetryCount_r <= QUICK_RETRY_LIMIT) begin
          quickRetryCount_nxt = quickRetryCount_r + 3'h1;
          tx_nxt = cmd(TX_QUICK_ENQ);
          timerStart = 1'b1;
        end else if (rxBad || tmo) begin
          fail_nxt = 1'b1;
          state_nxt = S_IDLE;
        end
      end
      default: state_nxt = S_IDLE;
    endcase
    // every abort out of an active wait, except the quick one, sends end
    if (state_nxt == S_IDLE && state_r != S_IDLE && !ok_nxt && state_r != S_QUICK) begin
      tx_nxt = cmd(TX_EOT);
      fail_nxt = 1'b1;
    end
    if (state_nxt == S_IDLE && ok_nxt && state_r == S_DATA_ACK) begin
      tx_nxt = cmd(TX_EOT);
    end
    if (state_nxt == S_IDLE) begin
      timerStop = 1'b1;
    end
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      enquiryRetryCount_r <= '0;
      headerRetryCount_r <= '0;
      blockRetryCount_r <= '0;
      quickRetryCount_r <= '0;
      blocksLeft_r <= '0;
      readDir_r <= 1'b0;
      txCmd_r <= '0;
      memFetch_r <= 1'b0;
      memDeliver_r <= 1'b0;
      busy_r <= 1'b0;
      doneOk_r <= 1'b0;
      doneFail_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      enquiryRetryCount_r <= enquiryRetryCount_nxt;
      headerRetryCount_r <= headerRetryCount_nxt;
      blockRetryCount_r <= blockRetryCount_nxt;
      quickRetryCount_r <= quickRetryCount_nxt;
      blocksLeft_r <= blocksLeft_nxt;
      readDir_r <= readDir_nxt;
      txCmd_r <= tx_nxt;
      memFetch_r <= fetch_nxt;
      memDeliver_r <= deliver_nxt;
      busy_r <= state_nxt != S_IDLE;
      doneOk_r <= ok_nxt;
      doneFail_r <= fail_nxt;
    end
  end

  // ---------------------------------------------------------------
  // reply timer, shared: only one wait is ever open at a time
  // ---------------------------------------------------------------
  reply_timer #(.W(TIMER_W)) replyTimer (
    .mclk(mclk),
    .rst(rst),
    .start(timerStart),
    .stop(timerStop),
    .load(timerLoad),
    .expired(timeout)
  );

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  AST_REQ_ENQ: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_IDLE && transferRequest.valid && !transferRequest.quick)
    |=> (txCmd_r == cmd(TX_ENQ) && state_r == S_ENQ_ACK && enquiryRetryCount_r == 6'h00))
    else $error("request did not send enquiry");

  AST_REQ_QUICK: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_IDLE && transferRequest.valid && transferRequest.quick)
    |=> (txCmd_r == cmd(TX_QUICK_ENQ) && state_r == S_QUICK))
    else $error("quick request did not send quick enquiry");

  AST_ENQ_ACKED: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_ENQ_ACK && rxAck) |=> (txCmd_r == cmd(TX_HEADER) && state_r == S_HDR_ACK))
    else $error("enquiry ack did not send header");

  AST_HDR_READ: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_HDR_ACK && rxAck && readDir_r) |=> (state_r == S_TEXT_START && !txCmd_r.valid))
    else $error("read header ack did not wait for text start");

  AST_ENQ_GIVEUP: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_ENQ_ACK && rxNak && enquiryRetryCount_r > ENQUIRY_RETRY_LIMIT)
    |=> (txCmd_r == cmd(TX_EOT) && state_r == S_IDLE))
    else $error("enquiry retry limit not honoured");

  AST_HDR_RETRY: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_HDR_ACK && rxNak && headerRetryCount_r <= HEADER_RETRY_LIMIT)
    |=> (txCmd_r == cmd(TX_HEADER) && headerRetryCount_r == $past(headerRetryCount_r) + 3'h1))
    else $error("header nak did not resend header");

  AST_STX_DATA: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_TEXT_START && rxStx) |=> (state_r == S_DATA) ##1 !timeout)
    else $error("start of text did not enter data wait");

  AST_QUICK_GIVEUP: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_QUICK && rxBad && quickRetryCount_r > QUICK_RETRY_LIMIT)
    |=> (state_r == S_IDLE && !txCmd_r.valid && doneFail_r))
    else $error("quick give-up wrong");

  AST_UNEXPECTED_EOT: assert property (@(posedge mclk) disable iff (rst)
    (state_r == S_DATA_ACK && rxEvent.valid && rxEvent.kind == RX_EOT)
    |=> (txCmd_r == cmd(TX_EOT) && state_r == S_IDLE))
    else $error("unexpected end did not abort");

endmodule

// *** logic/master_xfer_pkg.sv ***
/*
  shared types and constants for the serial link master sequencer.
  assumes a character receiver and transmitter on the same clock that
  decode and encode the link characters named here.
*/
package master_xfer_pkg;

  // ---------------------------------------------------------------
  // retry limits: a retry is allowed while the count is at most these
  // ---------------------------------------------------------------
  localparam logic [5:0] ENQUIRY_RETRY_LIMIT = 6'h20;
  localparam logic [2:0] BLOCK_RETRY_LIMIT = 3'h3;
  localparam logic [2:0] HEADER_RETRY_LIMIT = 3'h3;
  localparam logic [2:0] QUICK_RETRY_LIMIT = 3'h3;

  // ---------------------------------------------------------------
  // widths and default reply times in mclk cycles
  // ---------------------------------------------------------------
  localparam int TIMER_W = 16;
  localparam int BLOCKS_W = 8;
  localparam int ENQ_REPLY_CYCLES = 2000;
  localparam int HDR_REPLY_CYCLES = 2000;
  localparam int BLK_REPLY_CYCLES = 2000;
  localparam int TEXT_START_CYCLES = 2000;
  localparam int DATA_RECV_CYCLES = 2000;
  localparam int END_WAIT_CYCLES = 2000;

  // ---------------------------------------------------------------
  // link events and commands
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    RX_ACK, RX_NAK, RX_EOT, RX_SOH, RX_STX, RX_CHAR, RX_GOOD_DATA, RX_BAD_DATA
  } rx_kind_e;

  typedef enum logic [2:0] {
    TX_ENQ, TX_QUICK_ENQ, TX_HEADER, TX_DATA, TX_ACK, TX_NAK, TX_EOT
  } tx_kind_e;

  typedef struct packed {
    logic valid;
    rx_kind_e kind;
  } rx_event_s;

  typedef struct packed {
    logic valid;
    tx_kind_e kind;
  } tx_cmd_s;

  typedef struct packed {
    logic valid;
    logic quick;
    logic read;
    logic [BLOCKS_W-1:0] blocks;
  } xfer_req_s;

endpackage

// *** logic/reply_timer.sv ***
/*
  one-shot down counter used for every reply wait of the master.
  assumes start and stop come from logic on mclk; load is at least one.
*/
`timescale 1ns/1ps
module reply_timer
  import master_xfer_pkg::*;
#(
  parameter int W = TIMER_W
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic stop,
  input wire logic [W-1:0] load,
  output logic expired
);

  logic [W-1:0] count_r;
  logic running_r;
  wire lastTick = running_r && (count_r == {{(W-1){1'b0}}, 1'b1});

  // ---------------------------------------------------------------
  // counter
  // ---------------------------------------------------------------
  // a fresh start simply overwrites any count still running
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      count_r <= '0;
      running_r <= 1'b0;
      expired <= 1'b0;
    end else begin
      expired <= lastTick && !start && !stop;
      if (start) begin
        count_r <= load;
        running_r <= 1'b1;
      end else if (stop || lastTick) begin
        running_r <= 1'b0;
      end else if (running_r) begin
        count_r <= count_r - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end

  AST_TIMER_FIRE: assert property (@(posedge mclk) disable iff (rst)
    (lastTick && !start && !stop) |=> expired)
    else $error("timer did not expire at end of count");

  AST_TIMER_RESTART: assert property (@(posedge mclk) disable iff (rst)
    start |=> (!expired && running_r && count_r == $past(load)))
    else $error("timer restart did not replace the count");

endmodule

// *** verification/remote_station_model.sv ***
/*
  remote station on the far end of the serial link, seen at event level.
  assumes the master's commands arrive as one-cycle pulses on mclk and that
  the bench sets, per command kind, the reply to give (4'hf: stay silent).
*/
`timescale 1ns/1ps
module remote_station_model
  import master_xfer_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input tx_cmd_s txCmd,
  input wire logic [6:0][3:0] answerTab,
  input wire logic [3:0] delay,
  input rx_event_s inject,
  output rx_event_s rxEvent
);
  // ---------------------------------------------------------------
  // reply engine
  // ---------------------------------------------------------------
  logic [3:0] holdOff_r;
  logic [3:0] pending_r;
  rx_event_s reply_r;

  // a fresh command drops any reply still pending, as a real station would
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      holdOff_r <= 4'h0;
      pending_r <= 4'hf;
      reply_r <= '0;
    end else begin
      reply_r.valid <= 1'b0;
      // kind is junk between replies so nothing leans on a stale value
      reply_r.kind <= rx_kind_e'(~reply_r.kind);
      if (txCmd.valid) begin
        pending_r <= answerTab[txCmd.kind];
        holdOff_r <= delay;
      end else if (holdOff_r != 4'h0) begin
        holdOff_r <= holdOff_r - 4'h1;
        if (holdOff_r == 4'h1 && pending_r != 4'hf) begin
          reply_r.valid <= 1'b1;
          reply_r.kind <= rx_kind_e'(pending_r);
        end
      end
    end
  end

  // bench-injected characters cover the unsolicited traffic of a read
  assign rxEvent = inject.valid ? inject : reply_r;
endmodule

// *** verification/serial_master_transfer_fsm_bench.sv ***
/*
  self-checking bench of the serial link master sequencer.
  assumes the remote station model answers master commands from a table and
  that short reply times keep every timeout but the end wait within a few dozen cycles.
*/
`timescale 1ns/1ps
module serial_master_transfer_fsm_bench
  import master_xfer_pkg::*;
;
  // ---------------------------------------------------------------
  // clock, stimulus and observed traffic
  // ---------------------------------------------------------------
  localparam logic [3:0] NONE = 4'hf;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  xfer_req_s transferRequest = '0;
  rx_event_s inject = '0;
  rx_event_s rxEvent;
  tx_cmd_s txCmd_r;
  logic memDataValid = 1'b0;
  logic memFetch_r, memDeliver_r, busy_r, doneOk_r, doneFail_r;
  logic [6:0][3:0] answerTab = '1;
  logic [3:0] delay = 4'h1;
  logic [2:0] memWait = 3'h0;
  rx_kind_e odd[5] = '{RX_EOT, RX_SOH, RX_STX, RX_CHAR, RX_BAD_DATA};
  tx_kind_e txLog[$];
  tx_kind_e expQ[$];
  int okCnt, failCnt, fetchCnt, dlvCnt, failures, checked, cycles;

  always #5 mclk = ~mclk;

  serial_master_transfer_fsm #(.ENQ_REPLY(20), .HDR_REPLY(22), .BLK_REPLY(22),
    .TEXT_START(24), .DATA_RECV(24)) serial_master_transfer_fsm_i (
    .mclk(mclk), .rst(rst), .transferRequest(transferRequest), .rxEvent(rxEvent),
    .memDataValid(memDataValid), .txCmd_r(txCmd_r), .memFetch_r(memFetch_r),
    .memDeliver_r(memDeliver_r), .busy_r(busy_r), .doneOk_r(doneOk_r),
    .doneFail_r(doneFail_r));

  remote_station_model remote_station_model_i (.mclk(mclk), .rst(rst), .txCmd(txCmd_r),
    .answerTab(answerTab), .delay(delay), .inject(inject), .rxEvent(rxEvent));

  // ---------------------------------------------------------------
  // monitor, local memory and watchdog
  // ---------------------------------------------------------------
  always @(posedge mclk) begin
    if (rst === 1'b0) begin
      if (txCmd_r.valid === 1'b1) txLog.push_back(txCmd_r.kind);
      okCnt += int'(doneOk_r === 1'b1);
      failCnt += int'(doneFail_r === 1'b1);
      fetchCnt += int'(memFetch_r === 1'b1);
      dlvCnt += int'(memDeliver_r === 1'b1);
    end
  end

  // memory answers a fetch three to five cycles later
  always @(posedge mclk) begin
    memDataValid <= 1'b0;
    if (memFetch_r === 1'b1) memWait <= 3'(2 + $urandom % 3);
    else if (memWait != 3'h0) begin
      memWait <= memWait - 3'h1;
      if (memWait == 3'h1) memDataValid <= 1'b1;
    end
  end

  always @(posedge mclk) begin
    cycles++;
    if (cycles == 40000) begin
      failures++;
      summarize();
    end
  end

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", checked, failures);
    if (failures == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] %0t %s: seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic setTab(input logic [3:0] e, input logic [3:0] q, input logic [3:0] h,
                        input logic [3:0] d);
    answerTab <= {NONE, NONE, NONE, d, h, q, e};
    delay <= 4'(1 + $urandom % 4);
  endtask

  task automatic addExp(input tx_kind_e kind, input int n);
    repeat (n) expQ.push_back(kind);
  endtask

  task automatic start(input logic q, input logic r, input logic [7:0] n);
    txLog.delete();
    expQ.delete();
    okCnt = 0;
    failCnt = 0;
    fetchCnt = 0;
    dlvCnt = 0;
    @(posedge mclk);
    transferRequest <= '{valid: 1'b1, quick: q, read: r, blocks: n};
    @(posedge mclk);
    transferRequest.valid <= 1'b0;
  endtask

  task automatic rxPulse(input rx_kind_e kind);
    @(posedge mclk);
    inject <= '{valid: 1'b1, kind: kind};
    @(posedge mclk);
    inject <= '{valid: 1'b0, kind: rx_kind_e'(~kind)};
  endtask

  // the far side of a read: text start, then a block, n times or five bad ones
  task automatic readRun(input int n, input bit bad);
    int w;
    setTab(RX_ACK, NONE, RX_ACK, NONE);
    start(1'b0, 1'b1, 8'(n));
    w = 0;
    while (txLog.size() < 2 && w < 200) begin
      @(posedge mclk);
      w++;
    end
    repeat (8) @(posedge mclk);
    for (int b = 0; b < (bad ? 5 : n); b++) begin
      rxPulse(RX_STX);
      rxPulse(bad ? RX_BAD_DATA : RX_GOOD_DATA);
      repeat (3) @(posedge mclk);
    end
    if (!bad) rxPulse(RX_EOT);
  endtask

  task automatic finishFlow(input int ok, input int fetch, input int dlv);
    int w;
    w = 0;
    repeat (2) @(posedge mclk);
    while (busy_r !== 1'b0 && w < 3000) begin
      @(posedge mclk);
      w++;
    end
    repeat (3) @(posedge mclk);
    check(busy_r, 1'b0, "transfer never ended");
    check(txLog.size(), expQ.size(), "command count");
    foreach (expQ[i]) if (i < txLog.size()) check(txLog[i], expQ[i], "command kind");
    check(okCnt, ok, "good ends");
    check(failCnt, 1 - ok, "failed ends");
    check(fetchCnt, fetch, "memory fetches");
    check(dlvCnt, dlv, "memory deliveries");
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  initial begin
    int n;
    void'($urandom(32'h442f));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    // writes, block count zero acting as one; a second request while busy is dropped
    for (int k = 0; k < 5; k++) begin
      n = (k == 0) ? 0 : 1 + $urandom % 4;
      setTab(RX_ACK, NONE, RX_ACK, RX_ACK);
      start(1'b0, 1'b0, 8'(n));
      repeat (2) @(posedge mclk);
      transferRequest <= '{valid: 1'b1, quick: 1'b1, read: 1'b1, blocks: 8'h1};
      @(posedge mclk);
      transferRequest.valid <= 1'b0;
      addExp(TX_ENQ, 1);
      addExp(TX_HEADER, 1);
      addExp(TX_DATA, (n == 0) ? 1 : n);
      addExp(TX_EOT, 1);
      finishFlow(1, (n == 0) ? 1 : n, 0);
    end
    // enquiry refused, then unanswered, until the retry budget runs out
    for (int k = 0; k < 2; k++) begin
      setTab((k == 0) ? 4'(RX_NAK) : NONE, NONE, NONE, NONE);
      start(1'b0, 1'b0, 8'h1);
      addExp(TX_ENQ, 34);
      addExp(TX_EOT, 1);
      finishFlow(0, 0, 0);
    end
    // header refused five times, then header left unanswered
    for (int k = 0; k < 2; k++) begin
      setTab(RX_ACK, NONE, (k == 0) ? 4'(RX_NAK) : NONE, NONE);
      start(1'b0, 1'b0, 8'h1);
      addExp(TX_ENQ, 1);
      addExp(TX_HEADER, (k == 0) ? 5 : 1);
      addExp(TX_EOT, 1);
      finishFlow(0, 0, 0);
    end
    // first data block always refused: resent from the same fetch
    setTab(RX_ACK, NONE, RX_ACK, RX_NAK);
    start(1'b0, 1'b0, 8'h2);
    addExp(TX_ENQ, 1);
    addExp(TX_HEADER, 1);
    addExp(TX_DATA, 5);
    addExp(TX_EOT, 1);
    finishFlow(0, 1, 0);
    // data block answered by an end, then left unanswered: both abort with end
    for (int k = 0; k < 2; k++) begin
      setTab(RX_ACK, NONE, RX_ACK, (k == 0) ? 4'(RX_EOT) : NONE);
      start(1'b0, 1'b0, 8'h2);
      addExp(TX_ENQ, 1);
      addExp(TX_HEADER, 1);
      addExp(TX_DATA, 1);
      addExp(TX_EOT, 1);
      finishFlow(0, 1, 0);
    end
    // reads: good blocks, then a block that stays bad
    n = 1 + $urandom % 3;
    readRun(n, 1'b0);
    addExp(TX_ENQ, 1);
    addExp(TX_HEADER, 1);
    addExp(TX_ACK, n);
    finishFlow(1, 0, n);
    readRun(2, 1'b1);
    addExp(TX_ENQ, 1);
    addExp(TX_HEADER, 1);
    addExp(TX_NAK, 4);
    addExp(TX_EOT, 1);
    finishFlow(0, 0, 0);
    // quick enquiry answered well, badly, not at all; giving up sends nothing
    for (int k = 0; k < 3; k++) begin
      setTab(NONE, (k == 0) ? 4'(RX_GOOD_DATA) : ((k == 1) ? 4'(RX_BAD_DATA) : NONE),
             NONE, NONE);
      start(1'b1, 1'b0, 8'h1);
      addExp(TX_QUICK_ENQ, (k == 0) ? 1 : 5);
      finishFlow((k == 0) ? 1 : 0, 0, 0);
    end
    // stray characters while the enquiry reply is awaited
    foreach (odd[i]) begin
      setTab(NONE, NONE, NONE, NONE);
      start(1'b0, 1'b0, 8'h1);
      repeat (3) @(posedge mclk);
      rxPulse(odd[i]);
      addExp(TX_ENQ, 1);
      addExp(TX_EOT, 1);
      finishFlow(0, 0, 0);
    end
    summarize();
  end
endmodule
